/* hw/dac_host_ctrl.sv */
// host controller driving the converter's latch pins from a word queue
`timescale 1ns/1ps
module dac_host_ctrl
    import dac_host_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // user word queue: sel[0] input latch, sel[1] converter latch
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [dac_host_pkg::DATA_W-1:0] wr_word,
    input wire logic [1:0] wr_sel,
    // user clear request, one-cycle pulse
    input wire logic clear_req,
    // status
    output logic busy,
    // converter pins
    output logic [dac_host_pkg::DATA_W-1:0] data_bus,
    output logic write_strobe_n,
    output logic input_stage_enable_n,
    output logic dac_stage_enable_n,
    output logic half_scale_force_n
);
    import dac_host_pkg::*;

    logic fifo_valid;
    logic fifo_ready;
    logic [DATA_W+1:0] fifo_out;
    host_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    logic clear_pend_q;

    // word and selects travel together so enables stay tied to their data
    word_fifo #(.WIDTH(DATA_W + 2), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data({wr_sel, wr_word}),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_out)
    );

    // fifo only drains when a write starts, so a long clear back-pressures the user
    assign fifo_ready = (state_q == ST_IDLE) && !clear_pend_q && !clear_req;

    // clear request waits until any write in flight has ended
    always_ff @(posedge core_clk) begin
        if (rst) begin
            clear_pend_q <= 1'b0;
        end else if (clear_req && (state_q != ST_IDLE)) begin
            // idle serves the request at once; remembering it there would clear twice
            clear_pend_q <= 1'b1;
        end else if (state_q == ST_IDLE) begin
            clear_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= ST_CLEAR;
            cnt_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    cnt_q <= '0;
                    if (clear_pend_q || clear_req) begin
                        state_q <= ST_CLEAR;
                    end else if (fifo_valid) begin
                        state_q <= ST_SETUP;
                    end
                end
                // selects and data settle one cycle before the strobe falls
                ST_SETUP: begin
                    state_q <= ST_STROBE;
                end
                ST_STROBE: begin
                    if (cnt_q == CNT_W'(WP_CYC - 1)) begin
                        cnt_q <= '0;
                        state_q <= ST_HOLD;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_HOLD: begin
                    state_q <= ST_IDLE;
                end
                ST_CLEAR: begin
                    if (cnt_q == CNT_W'(CP_CYC - 1)) begin
                        cnt_q <= '0;
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    cnt_q <= '0;
                end
            endcase
        end
    end

    // pins: data and selects latched at pop, held through strobe and hold
    // every converter pin is driven from reset on, so none is left floating
    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_bus <= CODE_HALF;
            input_stage_enable_n <= 1'b1;
            dac_stage_enable_n <= 1'b1;
        end else if (fifo_valid && fifo_ready) begin
            data_bus <= fifo_out[DATA_W-1:0];
            input_stage_enable_n <= !fifo_out[DATA_W];
            dac_stage_enable_n <= !fifo_out[DATA_W+1];
        end else if (state_q == ST_HOLD) begin
            // selects released after strobe rises, giving the hold time
            input_stage_enable_n <= 1'b1;
            dac_stage_enable_n <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            write_strobe_n <= 1'b1;
        end else begin
            write_strobe_n <= !((state_q == ST_SETUP) ||
                ((state_q == ST_STROBE) && (cnt_q != CNT_W'(WP_CYC - 1))));
        end
    end

    // reset drives clear so the converter starts at half scale
    always_ff @(posedge core_clk) begin
        if (rst) begin
            half_scale_force_n <= 1'b0;
        end else begin
            // low for every clear state cycle, CP_CYC in all, meeting the minimum
            half_scale_force_n <= (state_q != ST_CLEAR);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy <= 1'b1;
        end else begin
            busy <= (state_q != ST_IDLE) || fifo_valid;
        end
    end

    // strobe is low exactly WP_CYC cycles
    a_strobe_width: assert property (@(posedge core_clk) disable iff (rst)
        $fell(write_strobe_n) |-> !write_strobe_n [*8] ##1 write_strobe_n)
        else $error("write strobe width wrong");

    // selects never change while strobe is low
    a_sel_stable: assert property (@(posedge core_clk) disable iff (rst)
        !write_strobe_n && !$fell(write_strobe_n) |->
        $stable(input_stage_enable_n) && $stable(dac_stage_enable_n))
        else $error("latch enable changed during strobe");

    // data stable while strobe is low
    a_data_stable: assert property (@(posedge core_clk) disable iff (rst)
        !write_strobe_n && !$fell(write_strobe_n) |-> $stable(data_bus))
        else $error("data changed during strobe");

    // no write while clear is asserted
    a_clear_excl: assert property (@(posedge core_clk) disable iff (rst)
        !half_scale_force_n |-> write_strobe_n)
        else $error("write during clear");

    // a queued word must not open a latch while clear is low
    a_clear_idle: assert property (@(posedge core_clk) disable iff (rst)
        !half_scale_force_n |-> input_stage_enable_n && dac_stage_enable_n)
        else $error("latch enabled during clear");

    // clear pulse lasts CP_CYC cycles, checked as three runs of low
    a_clear_width: assert property (@(posedge core_clk) disable iff (rst)
        $fell(half_scale_force_n) |-> !half_scale_force_n [*8] ##1
        !half_scale_force_n [*8] ##1 !half_scale_force_n [*4] ##1 half_scale_force_n)
        else $error("clear pulse width wrong");

    // a no-enable write still strobes, so only settling is required here
    a_sel_setup: assert property (@(posedge core_clk) disable iff (rst)
        $fell(write_strobe_n) |-> $stable(input_stage_enable_n) &&
        $stable(dac_stage_enable_n) && $stable(data_bus))
        else $error("strobe fell with unsettled select");

    // selects still held as the strobe rises, giving the hold time
    a_sel_hold: assert property (@(posedge core_clk) disable iff (rst)
        $rose(write_strobe_n) |->
        $stable(input_stage_enable_n) && $stable(dac_stage_enable_n))
        else $error("enables moved at strobe end");

    // enables release one cycle after strobe rises
    a_sel_release: assert property (@(posedge core_clk) disable iff (rst)
        $rose(write_strobe_n) |-> ##1 (input_stage_enable_n && dac_stage_enable_n))
        else $error("enables not released after write");

    // a clear request reaches the pin within one write time
    a_clear_resp: assert property (@(posedge core_clk) disable iff (rst)
        clear_req |-> ##[1:14] !half_scale_force_n)
        else $error("clear request not served");
endmodule

/* hw/dac_host_pkg.sv */
// constants for the host controller of a double-buffered 16-bit converter
package dac_host_pkg;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int CLK_PERIOD_NS = 10;
    // write strobe low time, least 50 ns; single-buffered needs 80 ns
    localparam int WP_NS = 80;
    localparam int WP_CYC = (WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // selects valid before strobe end, least 50 ns
    localparam int AW_NS = 50;
    localparam int AW_CYC = (AW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // hold after strobe end, least 10 ns
    localparam int AH_NS = 10;
    localparam int AH_CYC = (AH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // clear pulse, least 200 ns
    localparam int CP_NS = 200;
    localparam int CP_CYC = (CP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 6;
    localparam logic [15:0] CODE_FULL = 16'h7fff;
    localparam logic [15:0] CODE_ZERO = 16'h8000;
    localparam logic [15:0] CODE_HALF = 16'h0000;
    localparam logic [15:0] CODE_3Q = 16'h4000;
    localparam logic [15:0] CODE_1Q = 16'hc000;
    localparam int STEP_UV_X10 = 1520;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_STROBE = 3'b010,
        ST_HOLD = 3'b011,
        ST_CLEAR = 3'b100
    } host_state_t;
endpackage

/* hw/word_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic push;
    logic pop;

    // ready is a flop so the user side never sees the count adder
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_d;
            in_ready <= (cnt_d != (AW+1)'(DEPTH));
        end
    end
endmodule

/* tb/dac_latch_model.sv */
// behavioural model of the converter's double-buffered latch front end
`timescale 1ns/1ps
module dac_latch_model (
    // converter pins
    input wire logic [15:0] data_bus,
    input wire logic write_strobe_n,
    input wire logic input_stage_enable_n,
    input wire logic dac_stage_enable_n,
    input wire logic half_scale_force_n,
    // latch contents
    output logic [15:0] input_latch,
    output logic [15:0] dac_code
);
    logic [15:0] bus_lvl;

    // a floating data pin reads as low
    always @* begin
        for (int i = 0; i < 16; i++) bus_lvl[i] = (data_bus[i] === 1'b1);
    end

    // level latches, so any glitch on an enable window passes data
    always @* begin
        if (!half_scale_force_n) begin
            input_latch = 16'h0000;
            dac_code = 16'h0000; // half scale code
        end else begin
            if (!write_strobe_n && !input_stage_enable_n) begin
                input_latch = bus_lvl; // bit 15 msb
            end
            if (!write_strobe_n && !dac_stage_enable_n) begin
                dac_code = input_latch;
            end
        end
    end
endmodule

/* tb/test_dac_host_ctrl.sv */
// self-checking bench for the converter host controller
`timescale 1ns/1ps
module test_dac_host_ctrl;
    import dac_host_pkg::*;
    logic core_clk, rst, wr_valid, wr_ready, clear_req, busy, full_seen;
    logic [15:0] wr_word, data_bus, in_latch, dac_code;
    logic [1:0] wr_sel;
    logic write_strobe_n, input_stage_enable_n, dac_stage_enable_n, half_scale_force_n;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [15:0] codes [5] = '{CODE_3Q, CODE_1Q, 16'h0001, 16'hffff, CODE_ZERO};

    dac_host_ctrl dut (.core_clk(core_clk), .rst(rst), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_word(wr_word), .wr_sel(wr_sel), .clear_req(clear_req),
        .busy(busy), .data_bus(data_bus), .write_strobe_n(write_strobe_n),
        .input_stage_enable_n(input_stage_enable_n), .dac_stage_enable_n(dac_stage_enable_n),
        .half_scale_force_n(half_scale_force_n));
    dac_latch_model model (.data_bus(data_bus), .write_strobe_n(write_strobe_n),
        .input_stage_enable_n(input_stage_enable_n), .dac_stage_enable_n(dac_stage_enable_n),
        .half_scale_force_n(half_scale_force_n), .input_latch(in_latch), .dac_code(dac_code));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ready is a flop: judge it at a falling edge, then let the rising edge take the word
    task automatic push(input logic [15:0] w, input logic [1:0] s);
        @(negedge core_clk);
        wr_valid = 1'b1;
        wr_word = w;
        wr_sel = s;
        while (wr_ready !== 1'b1) begin
            full_seen = 1'b1;
            @(negedge core_clk);
        end
        @(posedge core_clk);
        @(negedge core_clk);
        wr_valid = 1'b0;
    endtask

    // busy is registered, so give it a few edges before polling
    task automatic wait_idle();
        repeat (3) @(negedge core_clk);
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge core_clk);
        check({15'h0000, busy}, 16'h0000, "busy after write");
    endtask

    task automatic t_reset();
        wait_idle();
        check(dac_code, CODE_HALF, "half scale after reset");
        check(in_latch, 16'h0000, "input latch after reset");
        $display("test reset done");
    endtask

    task automatic t_two_stage();
        push(CODE_FULL, 2'b01);
        wait_idle();
        check(dac_code, CODE_HALF, "converter latch untouched");
        check(in_latch, CODE_FULL, "input latch loaded");
        push(16'h1234, 2'b00);
        wait_idle();
        check(in_latch, CODE_FULL, "no-enable write");
        push(16'h5555, 2'b10);
        wait_idle();
        check(dac_code, CODE_FULL, "transfer to converter");
        $display("test two stage done");
    endtask

    task automatic t_codes();
        foreach (codes[i]) begin
            push(codes[i], 2'b11);
            wait_idle();
            check(dac_code, codes[i], "transparent code");
        end
        $display("test codes done");
    endtask

    task automatic t_fill();
        full_seen = 1'b0;
        for (int i = 0; i < 12; i++) push(16'h0100 + 16'(i), 2'b11);
        wait_idle();
        check({15'h0000, full_seen}, 16'h0001, "queue refused when full");
        check(dac_code, 16'h010b, "last queued word");
        $display("test fill done");
    endtask

    task automatic t_clear();
        push(CODE_FULL, 2'b11);
        @(negedge core_clk);
        clear_req = 1'b1;
        @(negedge core_clk);
        clear_req = 1'b0;
        push(CODE_3Q, 2'b01);
        wait_idle();
        check(dac_code, CODE_HALF, "clear to half scale");
        check(in_latch, CODE_3Q, "write after clear");
        $display("test clear done");
    endtask

    // ceiling well above the few hundred cycles the run's 22 writes take
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            test_done();
        end
    end

    initial begin
        rst = 1'b1;
        wr_valid = 1'b0;
        wr_word = 16'h0000;
        wr_sel = 2'b00;
        clear_req = 1'b0;
        full_seen = 1'b0;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        t_reset();
        t_two_stage();
        t_codes();
        t_fill();
        t_clear();
        test_done();
    end
endmodule
